// ### rtl/sense_params.svh
`ifndef SENSE_PARAMS_SVH
`define SENSE_PARAMS_SVH

// Clock rate and documented times
`define CORE_CLK_HZ        50000000
`define INSTR_PERIOD_NS    500
// Scaled per microsecond so no product overflows 32 bits
`define CLK_PER_US         (`CORE_CLK_HZ / 1000000)
`define INSTR_CYCLES       ((`INSTR_PERIOD_NS * `CLK_PER_US) / 1000)
`define SWITCH_PERIOD_NS   6500
`define HALF_SWITCH_CYCLES (((`SWITCH_PERIOD_NS / 2) * `CLK_PER_US) / 1000)
`define DISCHARGE_NS       100000
`define DISCHARGE_CYCLES   ((`DISCHARGE_NS * `CLK_PER_US) / 1000)
`define TRANSITION_CYCLES  2
`define SLEEP_S            60
`define SLEEP_CYCLES       (64'(`SLEEP_S) * 64'(`CORE_CLK_HZ))
`define COUNT_RESET        16'h0000
`endif

// ### rtl/sense_pkg.sv
package sense_pkg;
	typedef enum logic [3:0] {
		ST_INIT, ST_DISCHARGE, ST_CHARGE_GAP, ST_CHARGE, ST_SHARE_GAP,
		ST_SHARE, ST_CALIBRATE, ST_CALCULATE, ST_OUTPUT, ST_SLEEP
	} seq_state_type;

	typedef struct packed {
		logic o;
		logic oe;
	} pin_drive_type;

	typedef struct packed {
		pin_drive_type sense_charge_pin;
		pin_drive_type comparator_sense_pin;
		pin_drive_type cal_resistor_pin;
		pin_drive_type integrator_return_pin;
	} pin_bank_type;

	typedef struct packed {
		logic [15:0] switching_count;
		logic [15:0] calibration_count;
		logic        valid;
	} result_type;
endpackage

// ### rtl/tick_divider.sv
`timescale 1ns/1ps
module tick_divider #(
	parameter int DIVIDE = 25
) (
	input  wire logic core_clk,
	input  wire logic rst,
	input  wire logic run,
	output logic      tick
);
	typedef struct packed {
		logic [15:0] cnt;
	} div_state_type;

	div_state_type st_r;
	div_state_type st_nxt;

	always_comb begin
		st_nxt = st_r;
		tick = 1'b0;
		if (!run) begin
			st_nxt.cnt = 16'h0000;
		end else if (st_r.cnt == 16'(DIVIDE - 1)) begin
			st_nxt.cnt = 16'h0000;
			tick = 1'b1;
		end else begin
			st_nxt.cnt = st_r.cnt + 16'h0001;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end
endmodule

// ### rtl/cap_sense_sequencer.sv
`timescale 1ns/1ps
`include "sense_params.svh"
module cap_sense_sequencer #(
	// Sleep span exceeds a 32-bit int
	parameter int     COUNT_W     = 16,
	parameter longint SLEEP_TICKS = `SLEEP_CYCLES,
	parameter int     DISCH_TICKS = `DISCHARGE_CYCLES
) (
	input  wire logic               core_clk,
	input  wire logic               rst,
	input  wire logic               comp_above_upper,
	input  wire logic               comp_below_lower,
	input  wire logic               comparator_sense_in,
	output sense_pkg::pin_bank_type pins,
	output sense_pkg::result_type   result,
	output logic                    sleeping
);
	import sense_pkg::*;

	// ***********************************
	// Timing constants
	// ***********************************
	// Zero-length phases clamped to one cycle
	localparam int INSTR_DIV = (`INSTR_CYCLES < 1) ? 1 : `INSTR_CYCLES;
	localparam int HALF_SW   =
		(`HALF_SWITCH_CYCLES < 1) ? 1 : `HALF_SWITCH_CYCLES;
	localparam int GAP_CYC   =
		(`TRANSITION_CYCLES < 1) ? 1 : `TRANSITION_CYCLES;

	// ***********************************
	// Sequencer state
	// ***********************************
	typedef struct packed {
		seq_state_type        state;
		logic [31:0]          timer;
		logic [COUNT_W-1:0]   switching_count;
		logic [COUNT_W-1:0]   calibration_count;
		pin_bank_type         pins;
		result_type           result;
	} seq_type;

	seq_type     st_r;
	seq_type     st_nxt;
	logic        instr_tick;
	logic [31:0] phase_len;
	logic        phase_end;

	// ***********************************
	// Instruction clock, runs only while calibrating
	// ***********************************
	tick_divider #(
		.DIVIDE (INSTR_DIV)
	) u_instr_div (
		.core_clk (core_clk),
		.rst      (rst),
		.run      (st_r.state == ST_CALIBRATE),
		.tick     (instr_tick)
	);

	// ***********************************
	// Phase length per state
	// ***********************************
	// One compare serves every timed phase
	always_comb begin
		phase_len = 32'h0000_0001;
		case (st_r.state)
			ST_DISCHARGE: begin
				phase_len = 32'(DISCH_TICKS);
			end
			ST_CHARGE_GAP, ST_SHARE_GAP: begin
				phase_len = 32'(GAP_CYC);
			end
			ST_CHARGE, ST_SHARE: begin
				phase_len = 32'(HALF_SW);
			end
			ST_SLEEP: begin
				phase_len = 32'(SLEEP_TICKS);
			end
			default: begin
				phase_len = 32'h0000_0001;
			end
		endcase
	end

	// Timer counts from zero on phase entry
	assign phase_end = (st_r.timer + 32'h0000_0001) >= phase_len;

	// ***********************************
	// Sequencer
	// ***********************************
	always_comb begin
		st_nxt = st_r;
		st_nxt.timer = st_r.timer + 32'h0000_0001;
		st_nxt.result.valid = 1'b0;
		// Comparator pin always an undriven input
		st_nxt.pins.comparator_sense_pin = '0;
		case (st_r.state)
			ST_INIT: begin
				st_nxt.switching_count   = '0;
				st_nxt.calibration_count = '0;
				// Pins float while configuring
				st_nxt.pins.sense_charge_pin      = '0;
				st_nxt.pins.cal_resistor_pin      = '0;
				st_nxt.pins.integrator_return_pin = '0;
				st_nxt.timer = '0;
				st_nxt.state = ST_DISCHARGE;
			end
			ST_DISCHARGE: begin
				st_nxt.pins.sense_charge_pin      = '{o: 1'b0, oe: 1'b1};
				st_nxt.pins.cal_resistor_pin      = '{o: 1'b0, oe: 1'b1};
				st_nxt.pins.integrator_return_pin = '{o: 1'b0, oe: 1'b1};
				// Long enough to empty both capacitors
				if (phase_end) begin
					st_nxt.timer = '0;
					st_nxt.state = ST_CHARGE_GAP;
				end
			end
			ST_CHARGE_GAP: begin
				// Float everything before driving high
				st_nxt.pins.sense_charge_pin      = '0;
				st_nxt.pins.cal_resistor_pin      = '0;
				st_nxt.pins.integrator_return_pin = '0;
				if (phase_end) begin
					st_nxt.timer = '0;
					st_nxt.state = ST_CHARGE;
				end
			end
			ST_CHARGE: begin
				// Held high for half a switching period
				st_nxt.pins.sense_charge_pin = '{o: 1'b1, oe: 1'b1};
				if (phase_end) begin
					st_nxt.timer = '0;
					st_nxt.state = ST_SHARE_GAP;
				end
			end
			ST_SHARE_GAP: begin
				// Release the charge drive before sharing
				st_nxt.pins.sense_charge_pin      = '0;
				st_nxt.pins.integrator_return_pin = '0;
				if (phase_end) begin
					st_nxt.timer = '0;
					st_nxt.state = ST_SHARE;
				end
			end
			ST_SHARE: begin
				// Return pin low opens the share path
				st_nxt.pins.integrator_return_pin = '{o: 1'b0, oe: 1'b1};
				if (phase_end) begin
					st_nxt.timer = '0;
					// One completed charge/share pass
					st_nxt.switching_count =
						st_r.switching_count + 1'b1;
					// Threshold read once sharing has settled
					if (comp_above_upper) begin
						st_nxt.pins.integrator_return_pin = '0;
						st_nxt.state = ST_CALIBRATE;
					end else begin
						st_nxt.pins.integrator_return_pin = '0;
						st_nxt.state = ST_CHARGE_GAP;
					end
				end
			end
			ST_CALIBRATE: begin
				st_nxt.pins.sense_charge_pin      = '0;
				st_nxt.pins.cal_resistor_pin      = '{o: 1'b0, oe: 1'b1};
				st_nxt.pins.integrator_return_pin = '{o: 1'b0, oe: 1'b1};
				// Exit beats a tick in the same cycle
				if (comp_below_lower) begin
					st_nxt.timer = '0;
					st_nxt.state = ST_CALCULATE;
				end else if (instr_tick) begin
					st_nxt.calibration_count =
						st_r.calibration_count + 1'b1;
				end
			end
			ST_CALCULATE: begin
				// Counts frozen; capacitors discharging
				st_nxt.pins.sense_charge_pin      = '{o: 1'b0, oe: 1'b1};
				st_nxt.pins.cal_resistor_pin      = '{o: 1'b0, oe: 1'b1};
				st_nxt.pins.integrator_return_pin = '{o: 1'b0, oe: 1'b1};
				st_nxt.state = ST_OUTPUT;
			end
			ST_OUTPUT: begin
				// Counts copied once, held until next pass
				st_nxt.result.switching_count   = 16'(st_r.switching_count);
				st_nxt.result.calibration_count =
					16'(st_r.calibration_count);
				st_nxt.result.valid = 1'b1;
				st_nxt.timer = '0;
				st_nxt.state = ST_SLEEP;
			end
			ST_SLEEP: begin
				// Pins stay low from calculate onward
				if (phase_end) begin
					st_nxt.timer = '0;
					st_nxt.state = ST_INIT;
				end
			end
			default: begin
				// Unused codes restart cleanly
				st_nxt.state = ST_INIT;
			end
		endcase
	end

	// ***********************************
	// State register
	// ***********************************
	always_ff @(posedge core_clk) begin
		// Every pin floats while in reset
		if (rst) begin
			st_r <= '{state: ST_INIT, default: '0};
		end else begin
			st_r <= st_nxt;
		end
	end

	// ***********************************
	// Outputs
	// ***********************************
	assign pins     = st_r.pins;
	assign result   = st_r.result;
	assign sleeping = (st_r.state == ST_SLEEP);
endmodule

// ### sim/cap_sense_assertions.sv
`timescale 1ns/1ps
module sense_checker (
	input wire logic                    core_clk,
	input wire logic                    rst,
	input wire logic                    comp_above_upper,
	input wire logic                    comp_below_lower,
	input wire logic                    comparator_sense_in,
	input wire sense_pkg::pin_bank_type pins,
	input wire sense_pkg::result_type   result,
	input wire logic                    sleeping
);
	import sense_pkg::*;
	logic cal_pat;
	logic all_low;
	assign cal_pat = !pins.sense_charge_pin.oe && pins.cal_resistor_pin.oe
		&& pins.integrator_return_pin.oe && !pins.cal_resistor_pin.o
		&& !pins.integrator_return_pin.o;
	assign all_low = pins.sense_charge_pin.oe && !pins.sense_charge_pin.o
		&& pins.cal_resistor_pin.oe && !pins.cal_resistor_pin.o
		&& pins.integrator_return_pin.oe && !pins.integrator_return_pin.o;
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	sense_undriven_a: assert property (!pins.comparator_sense_pin.oe)
		else $error("comparator sense pin driven");
	cal_holds_a: assert property (cal_pat && !comp_below_lower
		|=> cal_pat) else $error("calibration left early");
	cal_exit_a: assert property (cal_pat && comp_below_lower
		|-> ##[1:2] pins.sense_charge_pin.oe) else $error("no exit");
	charge_gap_a: assert property ($rose(pins.sense_charge_pin.o)
		|-> $past(pins) == '0) else $error("no float before charge");
	no_crowbar_a: assert property (!(pins.sense_charge_pin.o
		&& pins.integrator_return_pin.oe)) else $error("crowbar");
	start_low_a: assert property ($fell(rst) |-> ##[1:3] all_low)
		else $error("discharge missing");
	sleep_low_a: assert property (sleeping && $past(sleeping)
		|-> all_low) else $error("pins not low in sleep");
	valid_sleep_a: assert property (result.valid |-> sleeping
		##1 !result.valid) else $error("valid not a pulse");
	count_hold_a: assert property (!result.valid
		|-> $stable(result[32:1])) else $error("counts moved");
	cover property (result.valid);
	cover property (cal_pat ##1 !cal_pat);
	cover property ($fell(sleeping));
endmodule
bind cap_sense_sequencer sense_checker chk_u (.core_clk(core_clk),
	.rst(rst), .comp_above_upper(comp_above_upper),
	.comp_below_lower(comp_below_lower),
	.comparator_sense_in(comparator_sense_in), .pins(pins),
	.result(result), .sleeping(sleeping));

// ### sim/sense_network.sv
`timescale 1ns/1ps
module sense_network #(
	parameter int SHARES = 3,
	parameter int DECAY  = 62
) (
	input  wire logic                    core_clk,
	input  wire sense_pkg::pin_bank_type pins,
	output logic                         comp_above_upper,
	output logic                         comp_below_lower,
	output logic                         comparator_sense_in
);
	import sense_pkg::*;
	int   passes;
	int   decay;
	logic p4_was;
	always begin
		comp_above_upper = passes >= SHARES && decay == 0;
		comp_below_lower = passes == 0 || decay >= DECAY;
		comparator_sense_in = comp_above_upper;
		@(posedge core_clk);
		#1;
		// Grounded sense pin empties both capacitors
		if (pins.sense_charge_pin.oe && !pins.sense_charge_pin.o) begin
			passes = 0;
			decay = 0;
		end else if (pins.cal_resistor_pin.oe) begin
			decay++;
		end else if (pins.integrator_return_pin.oe && !p4_was) begin
			passes++;
		end
		p4_was = pins.integrator_return_pin.oe;
	end
endmodule

// ### sim/tb_switched_cap_sense_sequencer.sv
`timescale 1ns/1ps
module tb_switched_cap_sense_sequencer;
	import sense_pkg::*;
	logic         core_clk;
	logic         rst;
	logic         above;
	logic         below;
	logic         sense_in;
	pin_bank_type pins;
	result_type   result;
	logic         sleeping;
	int           fail_count;
	int           total_checks;
	int           cycles;
	localparam int SLEEP_T = 100;
	cap_sense_sequencer #(.SLEEP_TICKS(SLEEP_T), .DISCH_TICKS(10)) dut_u (
		.core_clk(core_clk), .rst(rst), .comp_above_upper(above),
		.comp_below_lower(below), .comparator_sense_in(sense_in),
		.pins(pins), .result(result), .sleeping(sleeping));
	sense_network #(.SHARES(3), .DECAY(62)) net_u (.core_clk(core_clk),
		.pins(pins), .comp_above_upper(above), .comp_below_lower(below),
		.comparator_sense_in(sense_in));
	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end
	task automatic check(input string what, input logic [15:0] exp, got);
		total_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic measure(input string name);
		int n;
		n = 0;
		while (result.valid !== 1'b1 && n < 3000) begin
			@(posedge core_clk);
			#1;
			n++;
		end
		check("valid", 16'h0001, {15'h0, result.valid});
		check("switching", 16'h0003, result.switching_count);
		check("calibration", 16'h0002, result.calibration_count);
		check("sleeping", 16'h0001, {15'h0, sleeping});
		@(posedge core_clk);
		#1;
		check("switch hold", 16'h0003, result.switching_count);
		$display("test %s done", name);
	endtask
	task automatic sleep_span();
		int n;
		n = 0;
		while (sleeping === 1'b1 && n < 500) begin
			@(posedge core_clk);
			#1;
			n++;
		end
		check("sleep span", 16'(SLEEP_T - 1), 16'(n));
		$display("test sleep done");
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 5000) begin
			fail_count++;
			tally_and_finish();
		end
	end
	initial begin
		rst = 1'b1;
		repeat (3) @(posedge core_clk);
		#1 rst = 1'b0;
		measure("first");
		sleep_span();
		measure("second");
		tally_and_finish();
	end
endmodule
